// *** inc/osc_pkg.sv ***
package osc_pkg;
  // register map (byte addresses, one aligned word each)
  localparam logic [11:0] OSC_CTRL_ADDR = 12'h000; // oscillator_control
  localparam logic [11:0] OSC_KEY_ADDR = 12'h004;  // unlock key write port
  localparam logic [11:0] OSC_CFG_ADDR = 12'h008;  // config straps readback
  localparam logic [11:0] OSC_STAT_ADDR = 12'h00C; // switch engine status
  // oscillator_control field positions
  localparam int OSC_CUR_LSB = 12;
  localparam int OSC_NEXT_LSB = 8;
  localparam int OSC_SEL_LOCK_BIT = 7;
  localparam int OSC_PIN_LOCK_BIT = 6;
  localparam int OSC_PLL_LOCK_BIT = 5;
  localparam int OSC_FAIL_BIT = 3;
  localparam int OSC_PRI_SLEEP_BIT = 2;
  localparam int OSC_SEC_EN_BIT = 1;
  localparam int OSC_SWREQ_BIT = 0;
  // config word field positions (within cfg readback)
  localparam int OSC_CFG_SRC_LSB = 8;
  localparam int OSC_CFG_FCK_LSB = 6;
  localparam int OSC_CFG_PMD_LSB = 0;
  // unlock keys
  localparam logic [7:0] OSC_KEY_HI_A = 8'h78;
  localparam logic [7:0] OSC_KEY_HI_B = 8'h9A;
  localparam logic [7:0] OSC_KEY_LO_A = 8'h46;
  localparam logic [7:0] OSC_KEY_LO_B = 8'h57;
  // source codes
  localparam logic [2:0] OSC_SRC_FRC = 3'h0;
  localparam logic [2:0] OSC_SRC_FRC_PLL = 3'h1;
  localparam logic [2:0] OSC_SRC_PRI = 3'h2;
  localparam logic [2:0] OSC_SRC_PRI_PLL = 3'h3;
  localparam logic [2:0] OSC_SRC_SEC = 3'h4;
  localparam logic [2:0] OSC_SRC_LOW_POWER_INTERNAL_RC = 3'h5;
  localparam logic [2:0] OSC_SRC_RSVD = 3'h6;
  localparam logic [2:0] OSC_SRC_FRC_DIV = 3'h7;
  // primary submodes
  localparam logic [1:0] OSC_PMD_EC = 2'h0;
  localparam logic [1:0] OSC_PMD_XT = 2'h1;
  localparam logic [1:0] OSC_PMD_HS = 2'h2;
  localparam logic [1:0] OSC_PMD_OFF = 2'h3;
  // switch delay in cycles of the new clock
  localparam int OSC_SWITCH_CYCLES = 10;
  localparam logic [3:0] OSC_SWITCH_CNT = 4'(OSC_SWITCH_CYCLES);
  // reserved control bits 15, 11 and 4, forced to zero on read
  localparam logic [15:0] OSC_RSVD_MASK = 16'h8810;
endpackage

// *** inc/osc_cnt_if.sv ***
`timescale 1ns/10ps
// carries a start pulse and done pulse between engine and edge counter
interface osc_cnt_if;
  logic start; // begin counting new-clock edges
  logic tick;  // one new-clock edge seen
  logic done;  // count reached
  modport ctrl (output start, output tick, input done);
  modport cnt (input start, input tick, output done);
endinterface

// *** design/osc_edge_cnt.sv ***
`timescale 1ns/10ps
// counts edges of the incoming clock before the switch completes
module osc_edge_cnt
  import osc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  osc_cnt_if.cnt cif
);
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic done_reg;
  logic done_next;

  // next state: load on start, decrement on tick, pulse done at zero
  always_comb begin
    cnt_next = cnt_reg;
    done_next = 1'b0;
    if (cif.start) begin
      cnt_next = OSC_SWITCH_CNT;
    end else if (cif.tick && cnt_reg != 4'h0) begin
      cnt_next = cnt_reg - 4'h1;
      done_next = (cnt_reg == 4'h1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 4'h0;
      done_reg <= 1'b0;
    end else if (clk_en) begin
      cnt_reg <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign cif.done = done_reg;
endmodule

// *** design/osc_ctrl.sv ***
`timescale 1ns/10ps
module osc_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] initial_source_cfg,
  input wire logic [1:0] primary_submode_cfg,
  input wire logic [1:0] switch_monitor_cfg,
  input wire logic pin_map_lock_one_shot_cfg,
  input wire logic osc_out_pin_function_cfg,
  input wire logic pll_locked,
  input wire logic new_clk_tick,
  input wire logic clock_fail_detect,
  input wire logic sleep_mode,
  output logic [2:0] current_source,
  output logic fail_safe_monitor,
  output logic primary_osc_run,
  output logic secondary_osc_run,
  output logic pll_run,
  output logic osc_out_as_clock,
  output logic pin_map_lock
);
  import osc_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // state
  typedef enum {OSC_IDLE, OSC_WAIT} osc_sw_e;
  osc_sw_e sw_reg, sw_next;
  logic [2:0] cur_reg, cur_next;        // current_source
  logic [2:0] nxt_reg, nxt_next;        // next_source
  logic swreq_reg, swreq_next;          // switch_request
  logic sel_lock_reg, sel_lock_next;    // selection_lock
  logic pin_lock_reg, pin_lock_next;    // pin_map_lock
  logic pll_lock_reg, pll_lock_next;    // pll lock status
  logic fail_reg, fail_next;            // clock_fail_flag
  logic pri_sleep_reg, pri_sleep_next;  // primary_sleep_enable
  logic sec_en_reg, sec_en_next;        // secondary_osc_enable
  logic [1:0] key_reg, key_next;        // 0 none, 1 high first key seen, 2 low first key seen
  logic hi_open_reg, hi_open_next;      // high byte unlocked
  logic lo_open_reg, lo_open_next;      // low byte unlocked
  logic [31:0] rd_reg, rd_next;
  logic rdy_reg, rdy_next;
  logic err_reg, err_next;
  logic init_reg, init_next;            // config captured after reset
  logic start_pulse;
  osc_cnt_if cif ();

  // config decode
  logic sw_allowed, fail_safe_monitor_on, locked, pll_mode;
  assign sw_allowed = ~switch_monitor_cfg[1];
  assign fail_safe_monitor_on = (switch_monitor_cfg == 2'h0);
  assign locked = fail_safe_monitor_on & sel_lock_reg;
  assign pll_mode = (cur_reg == OSC_SRC_PRI_PLL) ||
                    (cur_reg == OSC_SRC_FRC_PLL);

  //////////////////////////////////////////////////////////////////////
  // bus decode
  logic acc, wr;
  logic [15:0] ctrl_view;
  assign acc = psel & penable & ~rdy_reg;
  assign wr = acc & pwrite;
  always_comb begin
    ctrl_view = 16'h0000;
    ctrl_view[OSC_CUR_LSB +: 3] = cur_reg;
    ctrl_view[OSC_NEXT_LSB +: 3] = nxt_reg;
    ctrl_view[OSC_SEL_LOCK_BIT] = sel_lock_reg;
    ctrl_view[OSC_PIN_LOCK_BIT] = pin_lock_reg;
    ctrl_view[OSC_PLL_LOCK_BIT] = pll_lock_reg;
    ctrl_view[OSC_FAIL_BIT] = fail_reg;
    ctrl_view[OSC_PRI_SLEEP_BIT] = pri_sleep_reg;
    ctrl_view[OSC_SEC_EN_BIT] = sec_en_reg;
    ctrl_view[OSC_SWREQ_BIT] = swreq_reg;
    ctrl_view = ctrl_view & ~OSC_RSVD_MASK;
  end

  //////////////////////////////////////////////////////////////////////
  // next-state logic for registers, unlock and switch engine
  always_comb begin
    sw_next = sw_reg;
    cur_next = cur_reg;
    nxt_next = nxt_reg;
    swreq_next = swreq_reg;
    sel_lock_next = sel_lock_reg;
    pin_lock_next = pin_lock_reg;
    fail_next = fail_reg;
    pri_sleep_next = pri_sleep_reg;
    sec_en_next = sec_en_reg;
    key_next = key_reg;
    hi_open_next = hi_open_reg;
    lo_open_next = lo_open_reg;
    rd_next = rd_reg;
    rdy_next = 1'b0;
    err_next = 1'b0;
    init_next = 1'b1;
    start_pulse = 1'b0;
    // capture straps on the first enabled edge after reset release
    if (!init_reg) begin
      cur_next = initial_source_cfg;
      nxt_next = initial_source_cfg;
    end
    if (acc) begin
      rdy_next = 1'b1;
      rd_next = 32'h0000_0000;
      case (paddr)
        OSC_CTRL_ADDR: begin
          if (!pwrite) begin
            rd_next = {16'h0000, ctrl_view};
          end else begin
            // keys open one write only
            if (pstrb[1] && hi_open_reg && !locked) begin
              nxt_next = pwdata[OSC_NEXT_LSB +: 3];
            end
            if (pstrb[0] && lo_open_reg) begin
              if (pwdata[OSC_SEL_LOCK_BIT]) begin
                sel_lock_next = 1'b1;
              end
              if (!(pin_map_lock_one_shot_cfg && pin_lock_reg)) begin
                pin_lock_next = pwdata[OSC_PIN_LOCK_BIT];
              end
              if (!pwdata[OSC_FAIL_BIT]) begin
                fail_next = 1'b0;
              end
              pri_sleep_next = pwdata[OSC_PRI_SLEEP_BIT];
              sec_en_next = pwdata[OSC_SEC_EN_BIT];
              if (pwdata[OSC_SWREQ_BIT] && sw_allowed && !locked) begin
                swreq_next = 1'b1;
              end
            end
            hi_open_next = 1'b0;
            lo_open_next = 1'b0;
          end
        end
        OSC_KEY_ADDR: begin
          if (pwrite) begin
            key_next = 2'h0;
            hi_open_next = 1'b0;
            lo_open_next = 1'b0;
            if (pwdata[7:0] == OSC_KEY_HI_A) begin
              key_next = 2'h1;
            end else if (pwdata[7:0] == OSC_KEY_LO_A) begin
              key_next = 2'h2;
            end else if (key_reg == 2'h1 &&
                         pwdata[7:0] == OSC_KEY_HI_B) begin
              hi_open_next = 1'b1;
            end else if (key_reg == 2'h2 &&
                         pwdata[7:0] == OSC_KEY_LO_B) begin
              lo_open_next = 1'b1;
            end
          end
        end
        OSC_CFG_ADDR: begin
          if (!pwrite) begin
            rd_next[OSC_CFG_SRC_LSB +: 3] = initial_source_cfg;
            rd_next[OSC_CFG_FCK_LSB +: 2] = switch_monitor_cfg;
            rd_next[OSC_CFG_PMD_LSB +: 2] = primary_submode_cfg;
          end
        end
        OSC_STAT_ADDR: begin
          if (!pwrite) begin
            rd_next[0] = (sw_reg == OSC_WAIT);
          end
        end
        default: begin
          err_next = 1'b1;
        end
      endcase
      // any other bus write breaks a key pair
      if (pwrite && paddr != OSC_KEY_ADDR) begin
        key_next = 2'h0;
      end
    end
    if (!sw_allowed) begin
      swreq_next = 1'b0;
    end
    // switch engine
    case (sw_reg)
      OSC_IDLE: begin
        if (swreq_reg) begin
          if (nxt_reg == cur_reg) begin
            swreq_next = 1'b0;
          end else begin
            fail_next = 1'b0;
            start_pulse = 1'b1;
            sw_next = OSC_WAIT;
          end
        end
      end
      OSC_WAIT: begin
        if (cif.done) begin
          cur_next = nxt_reg;
          swreq_next = 1'b0;
          sw_next = OSC_IDLE;
        end
      end
      default: begin
        sw_next = OSC_IDLE;
      end
    endcase
    if (fail_safe_monitor_on && clock_fail_detect) begin
      fail_next = 1'b1;
    end
  end

  // pll lock status: forced low while switching or not in pll mode
  always_comb begin
    pll_lock_next = pll_locked && pll_mode && sw_reg == OSC_IDLE &&
                    !start_pulse;
  end

  //////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_reg <= OSC_IDLE;
      cur_reg <= OSC_SRC_FRC_DIV;
      nxt_reg <= OSC_SRC_FRC_DIV;
      swreq_reg <= 1'b0;
      sel_lock_reg <= 1'b0;
      pin_lock_reg <= 1'b0;
      pll_lock_reg <= 1'b0;
      fail_reg <= 1'b0;
      pri_sleep_reg <= 1'b0;
      sec_en_reg <= 1'b0;
      key_reg <= 2'h0;
      hi_open_reg <= 1'b0;
      lo_open_reg <= 1'b0;
      rd_reg <= 32'h0000_0000;
      rdy_reg <= 1'b0;
      err_reg <= 1'b0;
      init_reg <= 1'b0;
    end else if (clk_en) begin
      sw_reg <= sw_next;
      cur_reg <= cur_next;
      nxt_reg <= nxt_next;
      swreq_reg <= swreq_next;
      sel_lock_reg <= sel_lock_next;
      pin_lock_reg <= pin_lock_next;
      pll_lock_reg <= pll_lock_next;
      fail_reg <= fail_next;
      pri_sleep_reg <= pri_sleep_next;
      sec_en_reg <= sec_en_next;
      key_reg <= key_next;
      hi_open_reg <= hi_open_next;
      lo_open_reg <= lo_open_next;
      rd_reg <= rd_next;
      rdy_reg <= rdy_next;
      err_reg <= err_next;
      init_reg <= init_next;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // oscillator enables, registered
  logic pri_reg, sec_reg, pllr_reg, oout_reg, fail_safe_monitor_reg;
  logic pri_sel;
  assign pri_sel = (cur_reg == OSC_SRC_PRI) || (cur_reg == OSC_SRC_PRI_PLL);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pri_reg <= 1'b0;
      sec_reg <= 1'b0;
      pllr_reg <= 1'b0;
      oout_reg <= 1'b0;
      fail_safe_monitor_reg <= 1'b0;
    end else if (clk_en) begin
      pri_reg <= pri_sel && primary_submode_cfg != OSC_PMD_OFF &&
                 (!sleep_mode || pri_sleep_reg);
      sec_reg <= sec_en_reg || cur_reg == OSC_SRC_SEC;
      pllr_reg <= pll_mode;
      // internal/secondary modes use the config bit; primary modes force it low
      oout_reg <= pri_sel ? 1'b0 : osc_out_pin_function_cfg;
      fail_safe_monitor_reg <= fail_safe_monitor_on;
    end
  end

  assign cif.start = start_pulse;
  assign cif.tick = new_clk_tick;
  osc_edge_cnt u_cnt (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .cif(cif)
  );

  assign prdata = rd_reg;
  assign pready = rdy_reg;
  assign pslverr = err_reg;
  assign current_source = cur_reg;
  assign fail_safe_monitor = fail_safe_monitor_reg;
  assign primary_osc_run = pri_reg;
  assign secondary_osc_run = sec_reg;
  assign pll_run = pllr_reg;
  assign osc_out_as_clock = oout_reg;
  assign pin_map_lock = pin_lock_reg;

  //////////////////////////////////////////////////////////////////////
  // checks
  property p_no_switch_cfg;
    @(posedge pclk) disable iff (!presetn)
    switch_monitor_cfg[1] |=> !swreq_reg;
  endproperty
  a_no_switch_cfg: assert property (p_no_switch_cfg) else $error("req set");
  property p_abort;
    @(posedge pclk) disable iff (!presetn)
    clk_en && init_reg && sw_reg == OSC_IDLE && swreq_reg &&
    nxt_reg == cur_reg |=> !swreq_reg;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  property p_pll_zero;
    @(posedge pclk) disable iff (!presetn)
    sw_reg == OSC_WAIT |=> !pll_lock_reg;
  endproperty
  a_pll_zero: assert property (p_pll_zero) else $error("pll lock");
  property p_rsvd;
    @(posedge pclk) disable iff (!presetn)
    rdy_reg && paddr == OSC_CTRL_ADDR |-> (prdata & 32'h0000_8810) == 0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("rsvd bits");
  property p_fail_set;
    @(posedge pclk) disable iff (!presetn)
    clk_en && fail_safe_monitor_on && clock_fail_detect |=> fail_reg;
  endproperty
  a_fail_set: assert property (p_fail_set) else $error("fail lost");
  property p_pin_hold;
    @(posedge pclk) disable iff (!presetn)
    pin_map_lock_one_shot_cfg && pin_lock_reg |=> pin_lock_reg;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin lock");
  property p_commit;
    @(posedge pclk) disable iff (!presetn)
    clk_en && sw_reg == OSC_WAIT && cif.done |=> cur_reg == $past(nxt_reg)
      && !swreq_reg;
  endproperty
  a_commit: assert property (p_commit) else $error("no commit");
  property p_locked;
    @(posedge pclk) disable iff (!presetn)
    locked && !swreq_reg |=> !swreq_reg;
  endproperty
  a_locked: assert property (p_locked) else $error("lock bypass");
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  import osc_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // stimulus and observed signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] isrc = 3'h7; // configured power-on source
  logic [1:0] pmd = 2'h3; // configured primary submode
  logic [1:0] fck = 2'h0; // switch and monitor configuration
  logic one_shot = 1'b1; // pin lock sticks once set
  logic pll_lk = 1'b1; // pll lock indication
  logic tick = 1'b0; // one pulse per new-clock edge
  logic fdet = 1'b0; // monitor failure indication
  logic sleep = 1'b0; // core asleep
  logic oo = 1'b1; // output pin carries the clock in internal modes
  logic [2:0] cur_src;
  logic fsm_on, pri_run, sec_run, pll_run, out_clk, pin_lock;
  int failures = 0;
  int checks = 0;
  logic [31:0] rd; // last read data
  logic err; // last error response
  // shadow of the control register, kept by the bench alone
  logic [2:0] s_cur, s_nxt;
  logic s_sl, s_pl, s_fl, s_pe, s_se;
  logic [2:0] codes [7] = '{3'h3, 3'h2, 3'h5, 3'h4, 3'h1, 3'h0, 3'h7};
  logic [31:0] r;

  // free-running bus clock, 20 ns period
  always #10 pclk = ~pclk;

  osc_ctrl dut_u (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .initial_source_cfg(isrc),
    .primary_submode_cfg(pmd), .switch_monitor_cfg(fck),
    .pin_map_lock_one_shot_cfg(one_shot), .osc_out_pin_function_cfg(oo),
    .pll_locked(pll_lk), .new_clk_tick(tick), .clock_fail_detect(fdet),
    .sleep_mode(sleep), .current_source(cur_src),
    .fail_safe_monitor(fsm_on), .primary_osc_run(pri_run),
    .secondary_osc_run(sec_run), .pll_run(pll_run),
    .osc_out_as_clock(out_clk), .pin_map_lock(pin_lock));

  ////////////////////////////////////////////////////////////////////////////
  // expected control word from the shadow state
  function automatic logic [31:0] exp_ctrl();
    logic lk;
    // lock status only means something in a multiplied mode
    lk = pll_lk & ((s_cur == OSC_SRC_FRC_PLL) | (s_cur == OSC_SRC_PRI_PLL));
    return {16'h0, 1'b0, s_cur, 1'b0, s_nxt, s_sl, s_pl, lk, 1'b0, s_fl,
      s_pe, s_se, 1'b0};
  endfunction

  // selection frozen: lock bit set with the monitor on
  function automatic logic sel_locked();
    return s_sl & (fck == 2'h0);
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 40) begin
      n++;
      @(posedge pclk);
    end
    if (n == 40) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle cycle so the next setup never lands in this time step
    @(posedge pclk);
  endtask

  task rd_ctrl;
    apb(1'b0, OSC_CTRL_ADDR, 32'h0, 4'h0);
    chk(rd, exp_ctrl());
  endtask

  // high byte write, optionally preceded by its key pair
  task hi_write(input logic [2:0] n, input logic keyed);
    if (keyed) begin
      apb(1'b1, OSC_KEY_ADDR, {24'h0, OSC_KEY_HI_A}, 4'h1);
      apb(1'b1, OSC_KEY_ADDR, {24'h0, OSC_KEY_HI_B}, 4'h1);
    end
    apb(1'b1, OSC_CTRL_ADDR, {21'h0, n, 8'h0}, 4'h2);
    if (keyed && !sel_locked())
      s_nxt = n;
  endtask

  // low byte write; the shadow follows each bit's access kind
  task lo_write(input logic [7:0] v, input logic keyed);
    if (keyed) begin
      apb(1'b1, OSC_KEY_ADDR, {24'h0, OSC_KEY_LO_A}, 4'h1);
      apb(1'b1, OSC_KEY_ADDR, {24'h0, OSC_KEY_LO_B}, 4'h1);
    end
    apb(1'b1, OSC_CTRL_ADDR, {24'h0, v}, 4'h1);
    if (keyed) begin
      s_sl = s_sl | v[7];
      if (!(one_shot && s_pl))
        s_pl = v[6];
      s_fl = s_fl & v[3];
      s_pe = v[2];
      s_se = v[1];
    end
  endtask

  task pulse(input int n);
    repeat (n) begin
      tick <= 1'b1;
      @(posedge pclk);
      tick <= 1'b0;
      @(posedge pclk);
    end
  endtask

  // full switch sequence; expectation follows the configuration
  task switch_to(input logic [2:0] n);
    logic ok;
    int k;
    ok = !fck[1] && !sel_locked();
    hi_write(n, 1'b1);
    lo_write({s_sl, s_pl, 2'b00, s_fl, s_pe, s_se, 1'b1}, 1'b1);
    pulse(OSC_SWITCH_CYCLES - 1);
    chk({29'h0, cur_src}, {29'h0, s_cur});
    if (ok && s_nxt != s_cur) begin
      apb(1'b0, OSC_CTRL_ADDR, 32'h0, 4'h0);
      chk({30'h0, rd[5], rd[0]}, 32'h1);
    end
    pulse(1);
    // busy flag is the completion handshake, polled with a bound
    k = 0;
    do begin
      apb(1'b0, OSC_STAT_ADDR, 32'h0, 4'h0);
      k++;
    end while (rd[0] === 1'b1 && k < 10);
    // a valid switch clears the failure flag as it starts
    if (ok && s_nxt != s_cur)
      s_fl = 1'b0;
    if (ok)
      s_cur = s_nxt;
    rd_ctrl();
    chk({29'h0, cur_src}, {29'h0, s_cur});
  endtask

  // reset with a fresh configuration, then load the shadow
  task do_reset(input logic [2:0] src, input logic [1:0] pm,
    input logic [1:0] fk, input logic os);
    presetn <= 1'b0;
    isrc <= src;
    pmd <= pm;
    fck <= fk;
    one_shot <= os;
    repeat (6) @(posedge pclk);
    chk({28'h0, pin_lock, cur_src}, 32'h7);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    s_cur = src;
    s_nxt = src;
    {s_sl, s_pl, s_fl, s_pe, s_se} = 5'h0;
    rd_ctrl();
    apb(1'b0, OSC_CFG_ADDR, 32'h0, 4'h0);
    chk(rd, {21'h0, src, fk, 4'h0, pm});
    chk({31'h0, fsm_on}, {31'h0, fk == 2'h0});
  endtask

  task print_verdict;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: far beyond the roughly one thousand cycles the sequence needs
  initial begin
    #(20 * 40000);
    failures++;
    print_verdict();
  end

  // main sequence
  initial begin
    void'($urandom(61));
    // erased part, switching and monitor both on
    do_reset(3'h7, 2'h3, 2'h0, 1'b1);
    apb(1'b0, 12'h010, 32'h0, 4'h0);
    chk({31'h0, err}, 32'h1);
    // unkeyed high byte is refused
    hi_write(3'h1, 1'b0);
    rd_ctrl();
    // every source code but the reserved one in turn, then random picks
    foreach (codes[i])
      switch_to(codes[i]);
    repeat (3) begin
      r = $urandom_range(7, 0);
      switch_to((r[2:0] == 3'h6) ? 3'h0 : r[2:0]);
    end
    // redundant switch aborts
    switch_to(s_cur);
    // multiplied mode with lock lost
    switch_to(OSC_SRC_FRC_PLL);
    pll_lk <= 1'b0;
    @(posedge pclk);
    rd_ctrl();
    pll_lk <= 1'b1;
    // failure flag: set by monitor, clear only
    fdet <= 1'b1;
    @(posedge pclk);
    fdet <= 1'b0;
    repeat (2) @(posedge pclk);
    s_fl = 1'b1;
    rd_ctrl();
    r = $urandom;
    lo_write({1'b0, r[6], 2'b00, 1'b1, r[2:1], 1'b0}, 1'b1);
    rd_ctrl();
    chk({31'h0, sec_run}, {31'h0, s_se});
    lo_write({1'b0, s_pl, 4'h0, ~s_se, 1'b0}, 1'b1);
    rd_ctrl();
    chk({31'h0, sec_run}, {31'h0, s_se});
    // pin lock sticks once set under one-shot
    lo_write(8'h40, 1'b1);
    lo_write(8'h00, 1'b1);
    rd_ctrl();
    chk({31'h0, pin_lock}, 32'h1);
    // primary kept or stopped in sleep, with the HS submode selected
    pmd <= 2'h2;
    switch_to(OSC_SRC_PRI);
    sleep <= 1'b1;
    lo_write({1'b0, s_pl, 6'h00}, 1'b1);
    chk({31'h0, pri_run}, 32'h0);
    lo_write({1'b0, s_pl, 6'h04}, 1'b1);
    chk({31'h0, pri_run}, 32'h1);
    sleep <= 1'b0;
    // selection lock freezes next source and request
    lo_write({1'b1, s_pl, 6'h04}, 1'b1);
    switch_to(OSC_SRC_LOW_POWER_INTERNAL_RC);
    // switching disabled by configuration
    do_reset(3'h3, 2'h1, 2'h2, 1'b1);
    switch_to(OSC_SRC_FRC);
    // monitor off: selection lock has no effect
    do_reset(3'h2, 2'h2, 2'h1, 1'b0);
    lo_write(8'h80, 1'b1);
    switch_to(OSC_SRC_SEC);
    chk({31'h0, out_clk}, {31'h0, oo});
    // pin lock needs keys, clears without one-shot
    lo_write(8'h40, 1'b0);
    chk({31'h0, pin_lock}, 32'h0);
    lo_write(8'h40, 1'b1);
    chk({31'h0, pin_lock}, 32'h1);
    lo_write(8'h00, 1'b1);
    rd_ctrl();
    print_verdict();
  end
endmodule
